// ===== tb/rsc_pin_debug_model.sv
// Model of the external reset pin and the debug programmer
`default_nettype none

module rsc_pin_debug_model #(
    parameter int HOLD_CYC = 8
) (
    input wire logic clk,
    input wire logic pin_go,
    input wire logic dbg_go,
    output logic pin_n,
    output logic dbg_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Press spans
    // ************************************************************
    int pin_cnt = 0;
    int dbg_cnt = 0;

    // Pin held low for a fixed span after a press, then released high
    always @(posedge clk) begin
        if (pin_go) pin_cnt <= HOLD_CYC;
        else if (pin_cnt > 0) pin_cnt <= pin_cnt - 1;
    end

    // Only this programmer raises the debug port reset request
    always @(posedge clk) begin
        if (dbg_go) dbg_cnt <= HOLD_CYC;
        else if (dbg_cnt > 0) dbg_cnt <= dbg_cnt - 1;
    end

    // Pin idles high, request idles low
    assign pin_n = (pin_cnt == 0);
    assign dbg_req = (dbg_cnt != 0);
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// Testbench of the reset source controller
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rsc_pkg::*;

    localparam int UNIT = 4;
    localparam int SCANW = 10;
    typedef struct {
        int src;
        logic [2:0] sel;
        logic [1:0] scan;
        logic [7:0] flags;
        int extra;
    } rsc_row_t;

    logic ref_clk = 1'b0;
    logic resetn, we, re, key_unlock, reset_pin_enable, brownout_active;
    logic wdt_timeout, pin_go, dbg_go, pin_n, dbg_req, scan_done = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] startup_delay_select;
    logic [1:0] scan_source_select;
    logic scan_run, sys_reset_n, override_reset_n, override_available;
    logic fuse_reload;
    int scan_cnt = 0;
    int bad_count = 0;
    int tests_run = 0;

    // Sources: 0 pin, 1 watchdog, 2 software, 3 debug, 4 brown-out
    rsc_row_t rows[6] = '{
        '{0, 3'h2, 2'h3, 8'h05, 0},
        '{1, 3'h2, 2'h3, 8'h0d, 0},
        '{2, 3'h0, 2'h3, 8'h1d, 0},
        '{3, 3'h0, 2'h3, 8'h3d, 0},
        '{4, 3'h2, 2'h3, 8'h3f, 2 * UNIT},
        '{0, 3'h0, 2'h0, 8'h3f, SCANW}
    };

    rsc_reset_source_controller #(.STARTUP_UNIT_CYC(UNIT)) uut (
        .REF_CLK(ref_clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
        .WE(we), .RE(re), .RDATA(rdata), .KEY_UNLOCK(key_unlock),
        .RESET_PIN_N(pin_n), .RESET_PIN_ENABLE(reset_pin_enable),
        .BROWNOUT_ACTIVE(brownout_active), .WDT_TIMEOUT(wdt_timeout),
        .DEBUG_RESET_REQ(dbg_req), .STARTUP_DELAY_SELECT(startup_delay_select),
        .SCAN_SOURCE_SELECT(scan_source_select), .SCAN_DONE(scan_done),
        .SCAN_RUN(scan_run), .SYS_RESET_N(sys_reset_n),
        .OVERRIDE_RESET_N(override_reset_n),
        .OVERRIDE_AVAILABLE(override_available), .FUSE_RELOAD(fuse_reload)
    );

    rsc_pin_debug_model #(.HOLD_CYC(8)) partner (
        .clk(ref_clk), .pin_go(pin_go), .dbg_go(dbg_go),
        .pin_n(pin_n), .dbg_req(dbg_req)
    );

    // Clock and checksum scan responder that finishes after SCANW cycles
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        scan_cnt <= scan_run ? scan_cnt + 1 : 0;
        scan_done <= scan_run && (scan_cnt >= SCANW - 1);
    end

    // ************************************************************
    // Compare and stimulus tasks
    // ************************************************************
    task automatic chk8(input string n, input logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_rng(input string n, input int lo, hi, g);
        tests_run++;
        if (g < lo || g > hi) begin
            bad_count++;
            $display("unexpected %s expected %0d to %0d seen %0d",
                n, lo, hi, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        re <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        re <= 1'b0;
        // Take the data mid-cycle while it stands, then realign to the edge
        @(negedge ref_clk);
        d = rdata;
        @(posedge ref_clk);
    endtask

    // Raise one reset source; software path unlocks first
    task automatic trigger(input int src);
        @(posedge ref_clk);
        case (src)
            0: pin_go <= 1'b1;
            1: wdt_timeout <= 1'b1;
            2: key_unlock <= 1'b1;
            3: dbg_go <= 1'b1;
            default: brownout_active <= 1'b1;
        endcase
        @(posedge ref_clk);
        pin_go <= 1'b0;
        wdt_timeout <= 1'b0;
        dbg_go <= 1'b0;
        key_unlock <= 1'b0;
        if (src == 2) wr(RSC_ADDR_SOFT_REQ, 8'h01);
        if (src == 4) repeat (5) @(posedge ref_clk);
        brownout_active <= 1'b0;
    endtask

    task automatic wait_low(output logic seen);
        int n;
        n = 0;
        seen = 1'b0;
        while (!seen && n < 4) begin
            @(posedge ref_clk);
            n++;
            seen = (sys_reset_n === 1'b0);
        end
    endtask

    task automatic hold_high(input int cyc, output logic ok);
        ok = 1'b1;
        repeat (cyc) begin
            @(posedge ref_clk);
            if (sys_reset_n !== 1'b1) ok = 1'b0;
        end
    endtask

    // Wait for init start, then count cycles until reset is released
    task automatic wait_boot(input logic ovr, output int len, output logic sc);
        int n;
        logic low_ok;
        n = 0;
        low_ok = 1'b1;
        sc = 1'b0;
        while (fuse_reload !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
            if (sys_reset_n !== 1'b0) low_ok = 1'b0;
        end
        chk_bit("reset held before init", 1'b1, low_ok);
        chk_bit("fuse reload", 1'b1, fuse_reload);
        chk_bit("override available", ovr, override_available);
        chk_bit("override reset", ovr, override_reset_n);
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
            if (scan_run === 1'b1) sc = 1'b1;
        end
        len = n;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #(20 * 20000);
        bad_count++;
        end_sim();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        int len, base;
        logic sc, seen;
        logic [7:0] d;
        {resetn, we, re, key_unlock, brownout_active} = '0;
        {wdt_timeout, pin_go, dbg_go} = '0;
        reset_pin_enable = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        startup_delay_select = 3'h0;
        scan_source_select = 2'h3;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        wait_boot(1'b0, base, sc);
        rd(RSC_ADDR_FLAGS, d);
        chk8("flags after power-on", 8'h01, d);
        foreach (rows[i]) begin
            startup_delay_select <= rows[i].sel;
            scan_source_select <= rows[i].scan;
            trigger(rows[i].src);
            wait_low(seen);
            chk_bit("reset entry", 1'b1, seen);
            wait_boot(1'b1, len, sc);
            chk_rng("boot length", base + rows[i].extra, base + rows[i].extra
                + (rows[i].scan != 2'h3 ? 3 : 0), len);
            chk_bit("scan phase", rows[i].scan != 2'h3, sc);
            rd(RSC_ADDR_FLAGS, d);
            chk8("cause flags", rows[i].flags, d);
        end
        scan_source_select <= 2'h3;
        wr(RSC_ADDR_FLAGS, 8'h00);
        rd(RSC_ADDR_FLAGS, d);
        chk8("flags after zero write", 8'h3f, d);
        wr(RSC_ADDR_FLAGS, 8'hc5);
        rd(RSC_ADDR_FLAGS, d);
        chk8("flags after partial clear", 8'h3a, d);
        wr(RSC_ADDR_SOFT_REQ, 8'h01);
        hold_high(20, seen);
        chk_bit("locked write ignored", 1'b1, seen);
        // Unlock, then let the window run out before the protected write
        @(posedge ref_clk);
        key_unlock <= 1'b1;
        @(posedge ref_clk);
        key_unlock <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wr(RSC_ADDR_SOFT_REQ, 8'h01);
        hold_high(20, seen);
        chk_bit("expired unlock ignored", 1'b1, seen);
        rd(RSC_ADDR_SOFT_REQ, d);
        chk8("trigger readback", 8'h00, d);
        rd(4'hf, d);
        chk8("unmapped read", 8'h00, d);
        reset_pin_enable <= 1'b0;
        trigger(0);
        hold_high(20, seen);
        chk_bit("disabled pin ignored", 1'b1, seen);
        reset_pin_enable <= 1'b1;
        // Second power-on with a watchdog hit during initialization
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_bit("override cleared", 1'b0, override_reset_n);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wdt_timeout <= 1'b1;
        @(posedge ref_clk);
        wdt_timeout <= 1'b0;
        wait_boot(1'b0, len, sc);
        rd(RSC_ADDR_FLAGS, d);
        chk8("flags after early watchdog", 8'h01, d);
        end_sim();
    end
endmodule

`default_nettype wire

// ===== verilog/rsc_pkg.sv
// Constants, encodings and state type of the reset source controller
`default_nettype none

package rsc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] RSC_ADDR_FLAGS = 4'h0;
    localparam logic [3:0] RSC_ADDR_SOFT_REQ = 4'h1;
    localparam logic [7:0] RSC_READ_ZERO = 8'h00;
    localparam logic [1:0] RSC_FLAGS_PAD = 2'h0;

    // ************************************************************
    // Field layout of the cause flags
    // ************************************************************
    localparam int RSC_NFLAGS = 6;
    localparam int RSC_BIT_DEBUG = 5;
    localparam int RSC_BIT_SOFT = 4;
    localparam int RSC_BIT_WDOG = 3;
    localparam int RSC_BIT_PIN = 2;
    localparam int RSC_BIT_BROWN = 1;
    localparam int RSC_BIT_POWER = 0;
    localparam int RSC_BIT_TRIGGER = 0;
    localparam logic [5:0] RSC_FLAGS_POR = 6'h01;
    localparam logic [5:0] RSC_FLAGS_NONE = 6'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int RSC_CLK_NS = 20;
    localparam int RSC_PULSE_NS = 50;
    localparam logic [1:0] RSC_PULSE_CYC =
        2'((RSC_PULSE_NS + RSC_CLK_NS - 1) / RSC_CLK_NS);
    localparam int RSC_STARTUP_UNIT_NS = 1000000;
    localparam int RSC_STARTUP_UNIT_CYC_DEF =
        RSC_STARTUP_UNIT_NS / RSC_CLK_NS;
    localparam logic [4:0] RSC_INIT_CYC = 5'h10;
    localparam logic [2:0] RSC_UNLOCK_WINDOW = 3'h4;

    // ************************************************************
    // Fuse encodings
    // ************************************************************
    localparam logic [1:0] RSC_SCAN_OFF = 2'h3;
    localparam logic [2:0] RSC_STARTUP_NONE = 3'h0;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [4:0] {
        RSC_ST_HOLD = 5'h01,
        RSC_ST_INIT = 5'h02,
        RSC_ST_START = 5'h04,
        RSC_ST_SCAN = 5'h08,
        RSC_ST_RUN = 5'h10
    } rsc_state_t;

endpackage

`default_nettype wire

// ===== verilog/rsc_reset_source_controller.sv
// Reset source controller: merges sources, sequences reset, records cause
`default_nettype none

// Operation
// - With pin option enabled, a low reset pin requests system reset.
// - Reset holds until the pin is high, then initialization follows.
// - Watchdog time-out issues a reset pulse of about 50 ns.
// - Writing one to trigger bit of software reset register resets system.
// - Software reset starts at once and holds until sequence completes.
// - Only power-on clears timer override settings; override stays usable.
// - Every reset type resets all other volatile logic.
// - First phase lasts while any source stays active.
// - Start-up delay added only after power-on or brown-out resets.
// - Enabled checksum scan lengthens initialization.
// - Controller works in active mode and all sleep modes.
// - Protected write without unlock is ignored, causing no reset.
// - Cause flags: debug, software, watchdog, pin, brown-out, power-on.
// - Writing one clears a flag; writing zero leaves it.
// - Power-on leaves only the power-on flag set.
// - No other flag sets after power-on until boot completes.
// - Trigger bit always reads zero.
// - Sources needing enable cannot request reset until enabled.
// - Fuse-loaded registers reload after every reset.
module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int unsigned STARTUP_UNIT_CYC = RSC_STARTUP_UNIT_CYC_DEF
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WE,
    input wire logic RE,
    output logic [7:0] RDATA,
    input wire logic KEY_UNLOCK,
    input wire logic RESET_PIN_N,
    input wire logic RESET_PIN_ENABLE,
    input wire logic BROWNOUT_ACTIVE,
    input wire logic WDT_TIMEOUT,
    input wire logic DEBUG_RESET_REQ,
    input wire logic [2:0] STARTUP_DELAY_SELECT,
    input wire logic [1:0] SCAN_SOURCE_SELECT,
    input wire logic SCAN_DONE,
    output logic SCAN_RUN,
    output logic SYS_RESET_N,
    output logic OVERRIDE_RESET_N,
    output logic OVERRIDE_AVAILABLE,
    output logic FUSE_RELOAD
);

    // ************************************************************
    // Declarations
    // ************************************************************
    rsc_state_t state_reg;
    rsc_state_t state_next;
    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    logic [5:0] set_vec;
    logic [5:0] clr_vec;
    logic [2:0] unlock_cnt_reg;
    logic [1:0] wdt_cnt_reg;
    logic [1:0] sw_cnt_reg;
    logic [4:0] init_cnt_reg;
    logic [31:0] unit_cnt_reg;
    logic [2:0] units_reg;
    logic supply_reg;
    logic por_seq_reg;
    logic boot_done_reg;
    logic sys_reset_n_reg;
    logic fuse_reload_reg;
    logic [7:0] rdata_reg;
    logic pin_req;
    logic sw_wr;
    logic sw_ok;
    logic sw_fire;
    logic wdt_act;
    logic sw_act;
    logic any_req;
    logic scan_en;
    logic init_done;
    logic unit_done;
    logic start_done;

    // ************************************************************
    // Source requests
    // ************************************************************
    // Pin request only counts when the fuse enables the pin
    assign pin_req = RESET_PIN_ENABLE & ~RESET_PIN_N;
    assign sw_wr = WE && (ADDR == RSC_ADDR_SOFT_REQ);
    assign sw_ok = sw_wr && (unlock_cnt_reg != 3'h0);
    assign sw_fire = sw_ok && WDATA[RSC_BIT_TRIGGER];
    assign wdt_act = (wdt_cnt_reg != 2'h0);
    assign sw_act = (sw_cnt_reg != 2'h0);
    // Debug request arrives only from the external debug port
    assign any_req = pin_req | BROWNOUT_ACTIVE | WDT_TIMEOUT | wdt_act
        | sw_fire | sw_act | DEBUG_RESET_REQ;
    assign scan_en = (SCAN_SOURCE_SELECT != RSC_SCAN_OFF);

    // Unlock window after the key write, consumed by a protected write
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            unlock_cnt_reg <= 3'h0;
        end else if (KEY_UNLOCK) begin
            unlock_cnt_reg <= RSC_UNLOCK_WINDOW;
        end else if (sw_ok) begin
            unlock_cnt_reg <= 3'h0;
        end else if (unlock_cnt_reg != 3'h0) begin
            unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
        end
    end

    // Watchdog reset pulse stretched to the minimum pulse width
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wdt_cnt_reg <= 2'h0;
        end else if (WDT_TIMEOUT) begin
            wdt_cnt_reg <= RSC_PULSE_CYC;
        end else if (wdt_act) begin
            wdt_cnt_reg <= wdt_cnt_reg - 2'h1;
        end
    end

    // Software reset pulse, started in the cycle of the write
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sw_cnt_reg <= 2'h0;
        end else if (sw_fire) begin
            sw_cnt_reg <= RSC_PULSE_CYC;
        end else if (sw_act) begin
            sw_cnt_reg <= sw_cnt_reg - 2'h1;
        end
    end

    // ************************************************************
    // Reset sequencer
    // ************************************************************
    assign init_done = (init_cnt_reg == RSC_INIT_CYC - 5'h01);
    assign unit_done = (unit_cnt_reg == 32'(STARTUP_UNIT_CYC - 1));
    assign start_done = unit_done
        && ((units_reg + 3'h1) == STARTUP_DELAY_SELECT);

    // Next state; any active source returns to the hold phase
    always_comb begin
        state_next = state_reg;
        if (any_req) begin
            state_next = RSC_ST_HOLD;
        end else begin
            case (state_reg)
                RSC_ST_HOLD: begin
                    state_next = RSC_ST_INIT;
                end
                RSC_ST_INIT: begin
                    if (init_done) begin
                        if (supply_reg
                            && STARTUP_DELAY_SELECT != RSC_STARTUP_NONE) begin
                            state_next = RSC_ST_START;
                        end else if (scan_en) begin
                            state_next = RSC_ST_SCAN;
                        end else begin
                            state_next = RSC_ST_RUN;
                        end
                    end
                end
                RSC_ST_START: begin
                    if (start_done) begin
                        state_next = scan_en ? RSC_ST_SCAN : RSC_ST_RUN;
                    end
                end
                RSC_ST_SCAN: begin
                    if (SCAN_DONE) begin
                        state_next = RSC_ST_RUN;
                    end
                end
                RSC_ST_RUN: begin
                    state_next = RSC_ST_RUN;
                end
                default: begin
                    state_next = RSC_ST_HOLD;
                end
            endcase
        end
    end

    // State register; free-running clock so sleep modes do not stop it
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= RSC_ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Base initialization counter
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            init_cnt_reg <= 5'h00;
        end else if (state_reg == RSC_ST_INIT && !init_done) begin
            init_cnt_reg <= init_cnt_reg + 5'h01;
        end else begin
            init_cnt_reg <= 5'h00;
        end
    end

    // Start-up extension, counted in whole units of the delay select
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            unit_cnt_reg <= 32'h0;
            units_reg <= 3'h0;
        end else if (state_reg != RSC_ST_START) begin
            unit_cnt_reg <= 32'h0;
            units_reg <= 3'h0;
        end else if (unit_done) begin
            unit_cnt_reg <= 32'h0;
            units_reg <= units_reg + 3'h1;
        end else begin
            unit_cnt_reg <= unit_cnt_reg + 32'h1;
        end
    end

    // Supply-type cause; power-on counts as one from the start
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            supply_reg <= 1'b1;
        end else if (BROWNOUT_ACTIVE) begin
            supply_reg <= 1'b1;
        end else if (state_reg == RSC_ST_RUN) begin
            supply_reg <= 1'b0;
        end
    end

    // Power-on sequence and boot tracking
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            por_seq_reg <= 1'b1;
            boot_done_reg <= 1'b0;
        end else if (state_reg == RSC_ST_RUN) begin
            por_seq_reg <= 1'b0;
            boot_done_reg <= 1'b1;
        end
    end

    // System reset and fuse reload strobe
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sys_reset_n_reg <= 1'b0;
            fuse_reload_reg <= 1'b0;
        end else begin
            sys_reset_n_reg <= (state_next == RSC_ST_RUN);
            fuse_reload_reg <= (state_reg == RSC_ST_HOLD)
                && (state_next == RSC_ST_INIT);
        end
    end

    // ************************************************************
    // Cause flags and register reads
    // ************************************************************
    // Flags are sampled while sources fire; blocked until first boot
    always_comb begin
        set_vec = RSC_FLAGS_NONE;
        set_vec[RSC_BIT_DEBUG] = DEBUG_RESET_REQ;
        set_vec[RSC_BIT_SOFT] = sw_fire | sw_act;
        set_vec[RSC_BIT_WDOG] = WDT_TIMEOUT | wdt_act;
        set_vec[RSC_BIT_PIN] = pin_req;
        set_vec[RSC_BIT_BROWN] = BROWNOUT_ACTIVE;
        set_vec = set_vec & {RSC_NFLAGS{boot_done_reg}};
        clr_vec = RSC_FLAGS_NONE;
        if (WE && ADDR == RSC_ADDR_FLAGS) begin
            clr_vec = WDATA[RSC_NFLAGS-1:0];
        end
        flags_next = (flags_reg & ~clr_vec) | set_vec;
    end

    // Power-on loads only the power-on flag; set wins over clear
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            flags_reg <= RSC_FLAGS_POR;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Read data one cycle after the strobe; trigger reads zero
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_reg <= RSC_READ_ZERO;
        end else if (RE && ADDR == RSC_ADDR_FLAGS) begin
            rdata_reg <= {RSC_FLAGS_PAD, flags_reg};
        end else begin
            rdata_reg <= RSC_READ_ZERO;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign RDATA = rdata_reg;
    assign SYS_RESET_N = sys_reset_n_reg;
    assign FUSE_RELOAD = fuse_reload_reg;
    assign SCAN_RUN = (state_reg == RSC_ST_SCAN);
    // Override settings cleared only during the power-on sequence
    assign OVERRIDE_RESET_N = ~por_seq_reg;
    assign OVERRIDE_AVAILABLE = ~por_seq_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_pin_holds_reset: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        pin_req |=> !SYS_RESET_N)
        else $error("pin low did not hold reset");

    a_pin_stays_hold: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        pin_req |=> state_reg == RSC_ST_HOLD)
        else $error("sequencer left hold with pin low");

    a_wdt_pulse_len: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        WDT_TIMEOUT |=> wdt_act [*3])
        else $error("watchdog pulse too short");

    a_sw_reset_fires: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        sw_fire |=> !SYS_RESET_N ##1 !SYS_RESET_N)
        else $error("software trigger gave no reset");

    a_sw_locked_write: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        sw_wr && unlock_cnt_reg == 3'h0 && !sw_act |=> !sw_act)
        else $error("unlocked write caused reset");

    a_trigger_reads_zero: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        RE && ADDR == RSC_ADDR_SOFT_REQ |=> RDATA == RSC_READ_ZERO)
        else $error("trigger bit read nonzero");

    a_flag_w1c: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        WE && ADDR == RSC_ADDR_FLAGS && set_vec == RSC_FLAGS_NONE
        |=> flags_reg == ($past(flags_reg) & ~$past(WDATA[5:0])))
        else $error("flag clear wrong");

    a_boot_blocks_flags: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        !boot_done_reg |-> flags_reg[5:1] == 5'h00)
        else $error("flag set before first boot");

    a_startup_supply: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        state_reg == RSC_ST_START |-> supply_reg)
        else $error("start-up delay without supply cause");

    a_scan_enabled: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        state_reg == RSC_ST_SCAN |-> scan_en)
        else $error("scan phase while scan disabled");

    a_override_kept: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        !por_seq_reg && !SYS_RESET_N |-> OVERRIDE_RESET_N
        && OVERRIDE_AVAILABLE)
        else $error("override cleared by non power-on reset");

    a_fuse_reload: assert property (@(posedge REF_CLK)
        disable iff (!RESETN)
        state_reg == RSC_ST_HOLD && !any_req |=> FUSE_RELOAD)
        else $error("no fuse reload after reset");

    c_sw_boot: cover property (@(posedge REF_CLK) disable iff (!RESETN)
        sw_fire ##[1:100] SYS_RESET_N);
    c_wdt_reset: cover property (@(posedge REF_CLK) disable iff (!RESETN)
        boot_done_reg && WDT_TIMEOUT ##1 flags_reg[RSC_BIT_WDOG]);
    c_scan_phase: cover property (@(posedge REF_CLK) disable iff (!RESETN)
        state_reg == RSC_ST_SCAN ##1 state_reg == RSC_ST_RUN);
    c_pin_reset: cover property (@(posedge REF_CLK) disable iff (!RESETN)
        boot_done_reg && pin_req ##1 !SYS_RESET_N);

endmodule

`default_nettype wire
